//--- core/lvp_pkg.sv
`default_nettype none

package lvp_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int          DATA_W       = 8;
    localparam int          MAG_W        = 6;
    localparam int          SEL_W        = 3;
    localparam int          NUM_XSTR     = 6;
    localparam logic [7:0]  REG_ONHOOK   = 8'h48;
    localparam logic [7:0]  REG_COMMON   = 8'h49;
    localparam logic [7:0]  REG_HIGH_BAT = 8'h4A;
    localparam logic [7:0]  REG_LOW_BAT  = 8'h4B;
    localparam logic [7:0]  REG_PWR_SEL  = 8'h4C;
    localparam logic [7:0]  REG_PWR_READ = 8'h4D;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int          POL_BIT      = 6;
    localparam logic        POL_RST      = 1'h0;
    localparam logic [5:0]  ONHOOK_RST   = 6'h20;
    localparam logic [5:0]  COMMON_RST   = 6'h02;
    localparam logic [5:0]  HIGH_RST     = 6'h32;
    localparam logic [5:0]  LOW_RST      = 6'h10;
    localparam logic [2:0]  SEL_RST      = 3'h0;
    localparam logic [2:0]  SEL_LAST     = 3'h5;
    localparam logic [2:0]  SEL_FINE_LO  = 3'h2;
    localparam logic [2:0]  SEL_FINE_HI  = 3'h3;
    localparam logic [7:0]  READ_ZERO    = 8'h00;

    // Host side register access, decoded from the serial control port
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lvp_req_type;

    // Programmed linefeed targets handed to the analog loops
    typedef struct packed {
        logic       polarity;
        logic [5:0] onhook_mag;
        logic [5:0] common_mode;
        logic [5:0] high_battery;
        logic [5:0] low_battery;
    } lvp_level_type;

    typedef logic [NUM_XSTR-1:0][DATA_W-1:0] lvp_power_type;

endpackage

`default_nettype wire

//--- core/lvp_regs.sv
// Functional notes
// RULE_01: On-hook bit 6 picks polarity; 0 positive, 1 negative tip minus ring.
// RULE_02: On-hook magnitude is six bits, 1.5 V steps, resets to 48 V code.
// RULE_03: Common-mode six-bit level sets tip forward or ring reverse, 1.5 V steps.
// RULE_04: High battery target is six bits, 1.5 V per step.
// RULE_05: Low battery target is six bits, 1.5 V per step.
// RULE_06: Software keeps high battery code at or above low battery code.
// RULE_07: Three-bit pointer selects transistors one to six; codes six, seven undefined.
// RULE_08: Read-only power register shows realtime power of selected transistor.
// RULE_09: Transistors one, two, five, six read at 30.4 mW per step.
// RULE_10: Transistors three and four read at 3.62 mW per step.
// RULE_11: Unused upper bits read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none

module lvp_regs
    import lvp_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          clk_en,
    input  wire logic          rst_b,
    input  wire lvp_req_type   req,
    input  wire lvp_power_type xstr_power,
    output var  logic [7:0]    rd_data,
    output var  logic          rd_valid,
    output var  lvp_level_type levels,
    output var  logic [2:0]    monitor_sel,
    output var  logic          monitor_fine_scale
);

    // ---------------------------------------------------------------
    // Decode helpers
    // ---------------------------------------------------------------

    // Transistors three and four use the fine power scale
    function automatic logic fine_scale(input logic [2:0] sel);
        fine_scale = (sel == SEL_FINE_LO) || (sel == SEL_FINE_HI);
    endfunction

    // Pointer codes past the sixth transistor are undefined
    function automatic logic sel_valid(input logic [2:0] sel);
        sel_valid = (sel <= SEL_LAST);
    endfunction

    function automatic logic hit(input lvp_req_type r, input logic [7:0] off);
        hit = (r.addr == off);
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    lvp_level_type levels_q;
    lvp_level_type levels_d;
    logic [2:0]    sel_q;
    logic [2:0]    sel_d;
    logic          fine_q;
    logic          fine_d;
    logic [7:0]    rd_data_q;
    logic [7:0]    rd_data_d;
    logic          rd_valid_q;
    logic          rd_valid_d;
    logic [7:0]    power_pick;

    // ---------------------------------------------------------------
    // Power monitor selection
    // ---------------------------------------------------------------

    // Undefined pointer codes read as zero rather than stale data; the
    // pointer itself keeps the code so software reads back what it wrote.
    // A plain mux of live samples: the value is the one present at the read edge
    always_comb begin
        power_pick = READ_ZERO;
        if (sel_valid(sel_q)) begin
            power_pick = xstr_power[sel_q];                             // RULE_07
        end
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------

    // Only the documented field bits are stored; upper bits are dropped
    always_comb begin
        levels_d = levels_q;
        sel_d    = sel_q;
        if (req.wr_en) begin
            if (hit(req, REG_ONHOOK)) begin
                levels_d.polarity   = req.wdata[POL_BIT];               // RULE_01
                levels_d.onhook_mag = req.wdata[MAG_W-1:0];             // RULE_02
            end
            if (hit(req, REG_COMMON)) begin
                levels_d.common_mode = req.wdata[MAG_W-1:0];            // RULE_03
            end
            // No ordering check between the battery codes: software owns it
            if (hit(req, REG_HIGH_BAT)) begin
                levels_d.high_battery = req.wdata[MAG_W-1:0];           // RULE_04
            end
            if (hit(req, REG_LOW_BAT)) begin
                levels_d.low_battery = req.wdata[MAG_W-1:0];            // RULE_05
            end
            if (hit(req, REG_PWR_SEL)) begin
                sel_d = req.wdata[SEL_W-1:0];                           // RULE_07
            end
        end
        fine_d = fine_scale(sel_d);                                     // RULE_09 RULE_10
    end

    // ---------------------------------------------------------------
    // Register reads
    // ---------------------------------------------------------------

    // Read data is registered so the port output comes from a flop
    always_comb begin
        rd_valid_d = req.rd_en;
        rd_data_d  = READ_ZERO;
        if (req.rd_en) begin
            unique case (req.addr)
                REG_ONHOOK:   rd_data_d = {1'h0, levels_q.polarity,
                                           levels_q.onhook_mag};        // RULE_11
                REG_COMMON:   rd_data_d = {2'h0, levels_q.common_mode}; // RULE_11
                REG_HIGH_BAT: rd_data_d = {2'h0, levels_q.high_battery};
                REG_LOW_BAT:  rd_data_d = {2'h0, levels_q.low_battery};
                REG_PWR_SEL:  rd_data_d = {5'h00, sel_q};               // RULE_11
                REG_PWR_READ: rd_data_d = power_pick;                   // RULE_08
                default:      rd_data_d = READ_ZERO;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Flops
    // ---------------------------------------------------------------

    // Reset wins over the clock enable; a low enable freezes everything
    // Reset is synchronous, so it needs a running clock to take effect
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            levels_q.polarity     <= POL_RST;
            levels_q.onhook_mag   <= ONHOOK_RST;                        // RULE_02
            levels_q.common_mode  <= COMMON_RST;
            levels_q.high_battery <= HIGH_RST;
            levels_q.low_battery  <= LOW_RST;
            sel_q                 <= SEL_RST;
            fine_q                <= 1'h0;
            rd_data_q             <= READ_ZERO;
            rd_valid_q            <= 1'h0;
        end else if (clk_en) begin
            levels_q   <= levels_d;
            sel_q      <= sel_d;
            fine_q     <= fine_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign rd_data            = rd_data_q;
    assign rd_valid           = rd_valid_q;
    assign levels             = levels_q;
    assign monitor_sel        = sel_q;
    assign monitor_fine_scale = fine_q;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    logic wr_go;
    logic rd_go;
    assign wr_go = clk_en && req.wr_en;
    assign rd_go = clk_en && req.rd_en;

    chk_polarity_write: assert property (@(posedge clock) disable iff (!rst_b) // RULE_01
        wr_go && hit(req, REG_ONHOOK) |=> levels.polarity == $past(req.wdata[POL_BIT]))
        else $error("on-hook polarity not stored");

    chk_onhook_reset: assert property (@(posedge clock) // RULE_02
        !rst_b |=> levels.onhook_mag == ONHOOK_RST && levels.polarity == POL_RST)
        else $error("on-hook reset value wrong");

    chk_common_write: assert property (@(posedge clock) disable iff (!rst_b) // RULE_03
        wr_go && hit(req, REG_COMMON) |=> levels.common_mode == $past(req.wdata[5:0]))
        else $error("common-mode level not stored");

    chk_high_bat_write: assert property (@(posedge clock) disable iff (!rst_b) // RULE_04
        wr_go && hit(req, REG_HIGH_BAT)
        |=> levels.high_battery == $past(req.wdata[5:0]) && $stable(levels.low_battery))
        else $error("high battery target wrong");

    chk_low_bat_write: assert property (@(posedge clock) disable iff (!rst_b) // RULE_05
        wr_go && hit(req, REG_LOW_BAT)
        |=> levels.low_battery == $past(req.wdata[5:0]) && $stable(levels.high_battery))
        else $error("low battery target wrong");

    chk_undef_sel_zero: assert property (@(posedge clock) disable iff (!rst_b) // RULE_07
        rd_go && hit(req, REG_PWR_READ) && !sel_valid(monitor_sel)
        |=> rd_valid && rd_data == READ_ZERO)
        else $error("undefined pointer read not zero");

    chk_power_track: assert property (@(posedge clock) disable iff (!rst_b) // RULE_08
        rd_go && hit(req, REG_PWR_READ) && sel_valid(monitor_sel)
        |=> rd_valid && rd_data == $past(xstr_power[monitor_sel]))
        else $error("power read not from selected transistor");

    chk_coarse_scale: assert property (@(posedge clock) disable iff (!rst_b) // RULE_09
        sel_valid(monitor_sel) && !fine_scale(monitor_sel) |-> !monitor_fine_scale)
        else $error("coarse transistor flagged fine");

    chk_fine_scale: assert property (@(posedge clock) disable iff (!rst_b) // RULE_10
        fine_scale(monitor_sel) |-> monitor_fine_scale)
        else $error("fine transistor not flagged");

    chk_reserved_zero: assert property (@(posedge clock) disable iff (!rst_b) // RULE_11
        rd_go && (hit(req, REG_COMMON) || hit(req, REG_PWR_SEL))
        |=> rd_data[7:6] == 2'h0 ##0 (!$past(hit(req, REG_PWR_SEL)) || rd_data[7:3] == 5'h00))
        else $error("reserved bits read nonzero");

    // ---------------------------------------------------------------
    // Field and map checks
    // ---------------------------------------------------------------

    // Pointer stores all three bits, undefined codes too
    chk_sel_write: assert property (@(posedge clock) disable iff (!rst_b) // RULE_07
        wr_go && hit(req, REG_PWR_SEL) |=> monitor_sel == $past(req.wdata[2:0]))
        else $error("power pointer not stored");

    // The power register has no storage behind it
    chk_ro_write_ignored: assert property (@(posedge clock) disable iff (!rst_b) // RULE_08
        wr_go && hit(req, REG_PWR_READ)
        |=> $stable(levels) && $stable(monitor_sel))
        else $error("write to power reading changed state");

    // Reads return the field as it stood at the taking edge
    chk_onhook_read: assert property (@(posedge clock) disable iff (!rst_b) // RULE_11
        rd_go && hit(req, REG_ONHOOK)
        |=> rd_data == {1'h0, $past(levels.polarity), $past(levels.onhook_mag)})
        else $error("on-hook read format wrong");

    chk_common_read: assert property (@(posedge clock) disable iff (!rst_b) // RULE_03
        rd_go && hit(req, REG_COMMON)
        |=> rd_data == {2'h0, $past(levels.common_mode)})
        else $error("common-mode read wrong");

    chk_high_read: assert property (@(posedge clock) disable iff (!rst_b) // RULE_04
        rd_go && hit(req, REG_HIGH_BAT)
        |=> rd_data == {2'h0, $past(levels.high_battery)})
        else $error("high battery read wrong");

    chk_low_read: assert property (@(posedge clock) disable iff (!rst_b) // RULE_05
        rd_go && hit(req, REG_LOW_BAT)
        |=> rd_data == {2'h0, $past(levels.low_battery)})
        else $error("low battery read wrong");

    chk_sel_read: assert property (@(posedge clock) disable iff (!rst_b) // RULE_11
        rd_go && hit(req, REG_PWR_SEL)
        |=> rd_data == {5'h00, $past(monitor_sel)})
        else $error("pointer read wrong");

    // Holes in the map still answer, with zero data
    chk_unmapped_read: assert property (@(posedge clock) disable iff (!rst_b) // RULE_11
        rd_go && !(req.addr inside {[REG_ONHOOK:REG_PWR_READ]})
        |=> rd_valid && rd_data == READ_ZERO)
        else $error("unmapped read not zero");

    // ---------------------------------------------------------------
    // Reset and enable checks
    // ---------------------------------------------------------------

    // One valid pulse per taken read, none otherwise
    chk_read_pulse: assert property (@(posedge clock) disable iff (!rst_b) // RULE_08
        clk_en |=> rd_valid == $past(req.rd_en))
        else $error("read valid pulse wrong");

    // A low enable must hold every register, outputs included
    chk_freeze_hold: assert property (@(posedge clock) disable iff (!rst_b) // RULE_02
        !clk_en
        |=> $stable(levels) && $stable(monitor_sel) && $stable(monitor_fine_scale)
            && $stable(rd_data) && $stable(rd_valid))
        else $error("state moved with clock enable low");

    // Every other field and the read port come back to their reset codes
    chk_levels_reset: assert property (@(posedge clock) // RULE_04
        !rst_b
        |=> levels.common_mode == COMMON_RST && levels.high_battery == HIGH_RST
            && levels.low_battery == LOW_RST && monitor_sel == SEL_RST
            && !monitor_fine_scale && !rd_valid && rd_data == READ_ZERO)
        else $error("reset values wrong");

    // ---------------------------------------------------------------
    // Cover points
    // ---------------------------------------------------------------

    cov_onhook_write: cover property (@(posedge clock) disable iff (!rst_b)
        wr_go && hit(req, REG_ONHOOK) ##1 rd_go && hit(req, REG_ONHOOK));

    cov_last_xstr_read: cover property (@(posedge clock) disable iff (!rst_b)
        rd_go && hit(req, REG_PWR_READ) && monitor_sel == SEL_LAST);

    cov_undef_read: cover property (@(posedge clock) disable iff (!rst_b)
        rd_go && hit(req, REG_PWR_READ) && !sel_valid(monitor_sel));

    cov_fine_read: cover property (@(posedge clock) disable iff (!rst_b)
        rd_go && hit(req, REG_PWR_READ) && monitor_fine_scale);

    cov_freeze_write: cover property (@(posedge clock) disable iff (!rst_b)
        !clk_en && req.wr_en);

endmodule

`default_nettype wire

//--- tb/lvp_line_model.sv
`timescale 1ns/100ps
`default_nettype none

module lvp_line_model
    import lvp_pkg::*;
(
    input  wire logic          clock,
    output var  lvp_power_type xstr_power,
    output var  logic [7:0]    tick
);
    // ---------------------------------------------------------------
    // Live power sense of the six line transistors
    // ---------------------------------------------------------------
    logic [7:0] tick_q = 8'h00;

    // Sample count moves every clock, so a stale power read shows up
    always_ff @(posedge clock) begin
        tick_q <= tick_q + 8'h01;
    end

    // Distinct value per transistor so a wrong pointer decode is seen
    always_comb begin
        for (int i = 0; i < NUM_XSTR; i++) begin
            xstr_power[i] = tick_q * 8'h1D + 8'(i) * 8'h2B;
        end
    end
    assign tick = tick_q;
endmodule

`default_nettype wire

//--- tb/linefeed_voltage_power_regs_test.sv
`timescale 1ns/100ps
`default_nettype none

module linefeed_voltage_power_regs_test;
    import lvp_pkg::*;
    // ---------------------------------------------------------------
    // Stimulus and harness
    // ---------------------------------------------------------------
    logic          clock  = 1'b0;
    logic          clk_en = 1'b1;
    logic          rst_b  = 1'b0;
    lvp_req_type   req    = '0;
    lvp_power_type xstr_power;
    lvp_level_type levels;
    logic [7:0]    rd_data;
    logic          rd_valid;
    logic [2:0]    monitor_sel;
    logic          monitor_fine_scale;
    logic [7:0]    tick;
    logic [7:0]    d;
    logic [7:0]    c;
    int            n_fail      = 0;
    int            check_count = 0;

    always #10 clock = ~clock;

    lvp_regs uut (.clock(clock), .clk_en(clk_en), .rst_b(rst_b), .req(req),
        .xstr_power(xstr_power), .rd_data(rd_data), .rd_valid(rd_valid), .levels(levels),
        .monitor_sel(monitor_sel), .monitor_fine_scale(monitor_fine_scale));
    lvp_line_model line (.clock(clock), .xstr_power(xstr_power), .tick(tick));

    // ---------------------------------------------------------------
    // Bus tasks and comparison
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        req <= '{1'b1, 1'b0, a, v};
        @(posedge clock);
        req <= '0;
    endtask

    // Tick seen at the taking edge tells which live sample was captured
    task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [7:0] t);
        @(posedge clock);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clock);
        req <= '0;
        // Answer stands from the taking edge until the next one
        #1 t = tick - 8'h01;
        chk("rd_valid", 8'h01, {7'h00, rd_valid});
        v = rd_data;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a, d, c);
        chk("rd_data", exp, d);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic check_reset();
        rdchk(REG_ONHOOK, 8'h20);
        rdchk(REG_COMMON, 8'h02);
        rdchk(REG_HIGH_BAT, 8'h32);
        rdchk(REG_LOW_BAT, 8'h10);
        rdchk(REG_PWR_SEL, 8'h00);
    endtask

    task automatic check_onhook();
        wr(REG_ONHOOK, 8'hFF);
        #1 chk("polarity", 8'h01, {7'h00, levels.polarity});
        chk("onhook_mag", 8'h3F, {2'h0, levels.onhook_mag});
        rdchk(REG_ONHOOK, 8'h7F);
        wr(REG_ONHOOK, 8'h95);
        #1 chk("polarity", 8'h00, {7'h00, levels.polarity});
        rdchk(REG_ONHOOK, 8'h15);
    endtask

    // Raise high battery before low, lower low before high
    task automatic check_levels();
        logic [7:0] a;
        for (int i = 0; i < 3; i++) begin
            a = REG_COMMON + 8'(i);
            wr(a, 8'hFF);
            rdchk(a, 8'h3F);
        end
        #1 chk("common_mode", 8'h3F, {2'h0, levels.common_mode});
        chk("high_battery", 8'h3F, {2'h0, levels.high_battery});
        chk("low_battery", 8'h3F, {2'h0, levels.low_battery});
        for (int i = 2; i >= 0; i--) begin
            a = REG_COMMON + 8'(i);
            wr(a, 8'hC0);
            rdchk(a, 8'h00);
        end
        #1 chk("low_battery", 8'h00, {2'h0, levels.low_battery});
    endtask

    // Every pointer code, undefined ones included
    task automatic check_pointer();
        logic [7:0] exp;
        for (int i = 0; i < 8; i++) begin
            wr(REG_PWR_SEL, 8'hF8 | 8'(i));
            #1 chk("monitor_sel", 8'(i), {5'h00, monitor_sel});
            chk("fine_scale", 8'((i == 2) || (i == 3)), {7'h00, monitor_fine_scale});
            rdchk(REG_PWR_SEL, 8'(i));
            rd(REG_PWR_READ, d, c);
            exp = (i < 6) ? c * 8'h1D + 8'(i) * 8'h2B : 8'h00;
            chk("power_reading", exp, d);
        end
    endtask

    task automatic check_refused();
        wr(REG_PWR_SEL, 8'h01);
        wr(REG_PWR_READ, 8'hAA);
        rd(REG_PWR_READ, d, c);
        chk("power_reading", c * 8'h1D + 8'h2B, d);
        wr(8'h50, 8'h3C);
        rdchk(8'h50, 8'h00);
    endtask

    // A write under a held clock enable must not land
    task automatic check_freeze();
        @(posedge clock);
        clk_en <= 1'b0;
        wr(REG_ONHOOK, 8'h0A);
        @(posedge clock);
        clk_en <= 1'b1;
        rdchk(REG_ONHOOK, 8'h15);
    endtask

    // Reset in mid-run brings back pointer, fine flag, on-hook and both battery fields
    task automatic check_midreset();
        wr(REG_HIGH_BAT, 8'h3A);
        wr(REG_PWR_SEL, 8'h03);
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        #1 chk("monitor_sel", 8'h00, {5'h00, monitor_sel});
        chk("fine_scale", 8'h00, {7'h00, monitor_fine_scale});
        chk("high_battery", 8'h32, {2'h0, levels.high_battery});
        rdchk(REG_ONHOOK, 8'h20);
        rdchk(REG_LOW_BAT, 8'h10);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        check_reset();
        check_onhook();
        check_levels();
        check_pointer();
        check_refused();
        check_freeze();
        check_midreset();
        tally_and_finish();
    end

    // Run needs about 130 cycles; cut a hang well beyond that
    initial begin
        #(20 * 4000);
        n_fail++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
